// ---- rtl/event_flag_latch.sv ----
// Sticky event flags: set by enabled events, cleared by read or write.
// Assumes set, enable and clears come from logic on the same clock.
module event_flag_latch #(
	parameter int WIDTH = 7
) (
	input  wire logic             clock,
	input  wire logic             reset_sync_n,
	input  wire logic [WIDTH-1:0] set_bits,
	input  wire logic [WIDTH-1:0] enable_bits,
	input  wire logic             clear_all,
	input  wire logic [WIDTH-1:0] clear_bits,
	output logic [WIDTH-1:0]      flags
);

	phy_irq_pkg::flag_state_t st;
	phy_irq_pkg::flag_state_t next_st;
	logic [WIDTH-1:0]         next_flags;

	// Per bit: an enabled event wins over any clear in the same cycle
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		assign next_flags[i] = (set_bits[i] & enable_bits[i])
			| (st.flags[i] & ~clear_all & ~clear_bits[i]);
	end

	always_comb begin
		next_st.flags = next_flags;
	end

	always_ff @(posedge clock or negedge reset_sync_n) begin
		if (!reset_sync_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign flags = st.flags;

endmodule

// ---- rtl/phy_irq_defs.svh ----
// Register indices, field positions, reset values of the PHY event block.
// Assumes inclusion by bare name from the design files.
`ifndef PHY_IRQ_DEFS_SVH
`define PHY_IRQ_DEFS_SVH

// Register indices on the management port
`define IDX_EVENT_CLEAR 5'h1C
`define IDX_EVENT_FLAGS 5'h1D
`define IDX_EVENT_MASK  5'h1E
`define IDX_SPECIAL     5'h1F

// Event field, bits 7 down to 1
`define EVT_HI          7
`define EVT_LO          1
`define EVT_COUNT       7
`define MASK_RESET      7'h00

// Special control/status fields
`define AUTODONE_BIT    12
`define RSV_HI          11
`define RSV_LO          5
`define RSV_RESET       7'h02
`define SPEED_HI        4
`define SPEED_LO        2
`define SPEED_EXT_RESET 3'h2
`define SPEED_INT_RESET 3'h0
`define LOW_HI          1
`define LOW_LO          0
`define LOW_RESET       2'h0

`endif

// ---- rtl/phy_irq_mask_special_status.sv ----
// PHY event mask, event flags and special control/status registers.
// Assumes a one-cycle management port and PHY status on the same clock.
//
// Added by the designer: the strobed register port.
`include "phy_irq_defs.svh"

module phy_irq_mask_special_status (
	input  wire logic                     clock,
	input  wire logic                     resetn,
	input  wire phy_irq_pkg::reg_req_t    reg_req,
	input  wire phy_irq_pkg::phy_status_t phy_stat,
	input  wire logic [6:0]               event_pulse,
	output logic [15:0]                   rdata,
	output logic                          irq
);

	localparam phy_irq_pkg::top_state_t ST_RESET = '{
		mask:       `MASK_RESET,
		rsv_field:  `RSV_RESET,
		low_bits:   `LOW_RESET,
		autodone:   1'b0,
		speed:      `SPEED_INT_RESET,
		speed_init: 1'b0,
		rdata:      16'h0000,
		irq:        1'b0
	};

	logic                     reset_sync_n;
	phy_irq_pkg::top_state_t  st;
	phy_irq_pkg::top_state_t  next_st;
	logic [6:0]               flags;
	logic [6:0]               clear_bits;
	logic [6:0]               armed;
	logic                     flags_read;
	logic                     hit_clear;
	logic                     hit_flags;
	logic                     hit_mask;
	logic                     hit_special;
	logic                     pending;
	logic [2:0]               speed_shown;

	// Reset release aligned to the clock
	reset_sync u_reset_sync (
		.clock        (clock),
		.resetn       (resetn),
		.reset_sync_n (reset_sync_n)
	);

	// Address decode
	assign hit_clear   = (reg_req.addr == `IDX_EVENT_CLEAR);
	assign hit_flags   = (reg_req.addr == `IDX_EVENT_FLAGS);
	assign hit_mask    = (reg_req.addr == `IDX_EVENT_MASK);
	assign hit_special = (reg_req.addr == `IDX_SPECIAL);

	// Clear sources for the sticky flags
	assign flags_read = reg_req.read & hit_flags;
	assign clear_bits = (reg_req.write & hit_clear) ? reg_req.wdata[`EVT_HI:`EVT_LO] : 7'h00;

	// Events that the mask lets through
	assign armed   = event_pulse & st.mask;
	assign pending = |(flags & st.mask);

	// start value shown until the first load
	assign speed_shown = st.speed_init ? st.speed
		: (phy_stat.ext_mii_mode ? `SPEED_EXT_RESET : `SPEED_INT_RESET);

	event_flag_latch #(
		.WIDTH (`EVT_COUNT)
	) u_flags (
		.clock        (clock),
		.reset_sync_n (reset_sync_n),
		.set_bits     (event_pulse),
		.enable_bits  (st.mask),
		.clear_all    (flags_read),
		.clear_bits   (clear_bits),
		.flags        (flags)
	);

	// Next state: register writes, status capture, read mux
	always_comb begin
		next_st = st;
		if (reg_req.write && hit_mask) begin
			next_st.mask = reg_req.wdata[`EVT_HI:`EVT_LO];
		end
		if (reg_req.write && hit_special) begin
			next_st.rsv_field = reg_req.wdata[`RSV_HI:`RSV_LO];
			next_st.low_bits  = reg_req.wdata[`LOW_HI:`LOW_LO];
		end
		next_st.autodone = phy_stat.autoneg_done;
		if (!st.speed_init) begin
			next_st.speed_init = 1'b1;
			next_st.speed      = phy_stat.ext_mii_mode ? `SPEED_EXT_RESET : `SPEED_INT_RESET;
		end else if (phy_stat.speed_valid) begin
			next_st.speed = phy_stat.speed_code;
		end
		next_st.irq = pending;
		next_st.rdata = 16'h0000;
		if (reg_req.read) begin
			case (reg_req.addr)
				`IDX_EVENT_FLAGS: begin
					next_st.rdata[`EVT_HI:`EVT_LO] = flags;
				end
				`IDX_EVENT_MASK: begin
					next_st.rdata[`EVT_HI:`EVT_LO] = st.mask;
				end
				`IDX_SPECIAL: begin
					next_st.rdata[`AUTODONE_BIT]     = st.autodone;
					next_st.rdata[`RSV_HI:`RSV_LO]   = st.rsv_field;
					next_st.rdata[`SPEED_HI:`SPEED_LO] = speed_shown;
					next_st.rdata[`LOW_HI:`LOW_LO]   = st.low_bits;
				end
				default: begin
					next_st.rdata = 16'h0000;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge clock or negedge reset_sync_n) begin
		if (!reset_sync_n) begin
			st <= ST_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign rdata = st.rdata;
	assign irq   = st.irq;

	// Checks on the registered behaviour
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_sync_n);

	mask_write_a: assert property (
		reg_req.write && hit_mask |=> st.mask == $past(reg_req.wdata[7:1])
	) else $error("mask write not stored");

	mask_read_a: assert property (
		reg_req.read && hit_mask |=> rdata[15:8] == 8'h00 && !rdata[0]
			&& rdata[7:1] == $past(st.mask)
	) else $error("mask readback wrong");

	flag_set_a: assert property (
		|armed |=> (flags & $past(armed)) == $past(armed)
	) else $error("enabled event not latched");

	flag_block_a: assert property (
		1'b1 |=> (flags & ~$past(flags) & ~$past(armed)) == 7'h00
	) else $error("flag rose without enabled event");

	flag_clear_a: assert property (
		flags_read && !(|armed) |=> flags == 7'h00
	) else $error("read did not clear flags");

	flag_read_a: assert property (
		flags_read |=> rdata[15:8] == 8'h00 && !rdata[0] && rdata[7:1] == $past(flags)
	) else $error("flag readback wrong");

	flag_page_a: assert property (
		armed[0] && !flags[0] ##1 reg_req.read && hit_flags |=> rdata[1]
	) else $error("page event missing in readback");

	irq_level_a: assert property (
		pending ##1 pending |-> irq
	) else $error("request missing while enabled flag set");

	irq_drop_a: assert property (
		!pending ##1 !pending |-> !irq
	) else $error("request stays with no enabled flag");

	special_read_a: assert property (
		reg_req.read && hit_special |=> rdata[15:13] == 3'h0
			&& rdata[11:5] == $past(st.rsv_field)
	) else $error("special readback wrong");

	autodone_a: assert property (
		phy_stat.autoneg_done ##1 (reg_req.read && hit_special) |=> rdata[12]
	) else $error("autoneg done not reported");

	rsv_write_a: assert property (
		reg_req.write && hit_special |=> st.rsv_field == $past(reg_req.wdata[11:5])
	) else $error("reserved field write lost");

	speed_track_a: assert property (
		st.speed_init && phy_stat.speed_valid |=> st.speed == $past(phy_stat.speed_code)
	) else $error("speed not tracked");

	speed_start_a: assert property (
		$rose(st.speed_init) |-> st.speed == ($past(phy_stat.ext_mii_mode) ? 3'h2 : 3'h0)
	) else $error("speed start value wrong");

	// Register hold, write, tracking and readback checks
	mask_hold_a: assert property (
		!(reg_req.write && hit_mask) |=> $stable(st.mask)
	) else $error("mask changed without a write");

	rsv_hold_a: assert property (
		!(reg_req.write && hit_special) |=> $stable(st.rsv_field)
	) else $error("reserved field changed without a write");

	low_write_a: assert property (
		reg_req.write && hit_special |=> st.low_bits == $past(reg_req.wdata[1:0])
	) else $error("low field write lost");

	unmapped_read_a: assert property (
		reg_req.read && !(hit_flags || hit_mask || hit_special) |=> rdata == 16'h0000
	) else $error("unmapped index read not zero");

	rdata_idle_a: assert property (
		!reg_req.read |=> rdata == 16'h0000
	) else $error("read data not cleared after one cycle");

	speed_read_a: assert property (
		st.speed_init && reg_req.read && hit_special |=> rdata[4:2] == $past(st.speed)
	) else $error("speed readback wrong");

	speed_hold_a: assert property (
		st.speed_init && !phy_stat.speed_valid |=> $stable(st.speed)
	) else $error("speed changed without a valid code");

	autodone_track_a: assert property (
		st.speed_init |=> st.autodone == $past(phy_stat.autoneg_done)
	) else $error("autoneg status not tracked");

	autodone_low_a: assert property (
		st.speed_init && !phy_stat.autoneg_done
			##1 (reg_req.read && hit_special) |=> !rdata[12]
	) else $error("autoneg shown done while incomplete");

	// Flag hold, clear and per-source blocking
	flag_hold_a: assert property (
		!flags_read |=> (flags & $past(flags & ~clear_bits))
			== $past(flags & ~clear_bits)
	) else $error("flag lost without a clear");

	clear_reg_a: assert property (
		reg_req.write && hit_clear
			|=> (flags & $past(reg_req.wdata[7:1]) & ~$past(armed)) == 7'h00
	) else $error("clear write left a flag set");

	energy_block_a: assert property (
		event_pulse[6] && !st.mask[6] && !flags[6] |=> !flags[6]
	) else $error("masked energy event latched");

	autoneg_block_a: assert property (
		event_pulse[5] && !st.mask[5] && !flags[5] |=> !flags[5]
	) else $error("masked autoneg event latched");

	remote_block_a: assert property (
		event_pulse[4] && !st.mask[4] && !flags[4] |=> !flags[4]
	) else $error("masked remote fault latched");

	link_block_a: assert property (
		event_pulse[3] && !st.mask[3] && !flags[3] |=> !flags[3]
	) else $error("masked link-down event latched");

	ack_block_a: assert property (
		event_pulse[2] && !st.mask[2] && !flags[2] |=> !flags[2]
	) else $error("masked partner ack latched");

	parallel_block_a: assert property (
		event_pulse[1] && !st.mask[1] && !flags[1] |=> !flags[1]
	) else $error("masked parallel fault latched");

	page_block_a: assert property (
		event_pulse[0] && !st.mask[0] && !flags[0] |=> !flags[0]
	) else $error("masked page event latched");

	irq_mask_off_a: assert property (
		!(|st.mask) |=> !irq
	) else $error("request with every source masked");

	irq_rise_c: cover property ($rose(irq));
	flag_clear_c: cover property (flags != 7'h00 ##1 flags_read ##1 flags == 7'h00);
	speed_full_c: cover property (st.speed == 3'h6);
	mask_block_c: cover property (|(event_pulse & ~st.mask) ##1 !irq);
	set_wins_c: cover property (flags_read && |armed);

endmodule

// ---- rtl/phy_irq_pkg.sv ----
// Types shared by the PHY event block and its helpers.
// Assumes compilation before every design module.
package phy_irq_pkg;

	typedef logic [4:0] reg_index_t;

	// One management access
	typedef struct packed {
		reg_index_t  addr;
		logic [15:0] wdata;
		logic        write;
		logic        read;
	} reg_req_t;

	// Live status from the PHY core
	typedef struct packed {
		logic       autoneg_done;
		logic       speed_valid;
		logic [2:0] speed_code;
		logic       ext_mii_mode;
	} phy_status_t;

	// Whole state of the top module
	typedef struct packed {
		logic [6:0]  mask;
		logic [6:0]  rsv_field;
		logic [1:0]  low_bits;
		logic        autodone;
		logic [2:0]  speed;
		logic        speed_init;
		logic [15:0] rdata;
		logic        irq;
	} top_state_t;

	typedef struct packed {
		logic [1:0] stage;
	} sync_state_t;

	typedef struct packed {
		logic [6:0] flags;
	} flag_state_t;

endpackage

// ---- rtl/reset_sync.sv ----
// Two-stage synchroniser for the release of the active-low reset.
// Assumes resetn may drop at any time; release is made clock-aligned.
module reset_sync (
	input  wire logic clock,
	input  wire logic resetn,
	output logic      reset_sync_n
);

	phy_irq_pkg::sync_state_t st;
	phy_irq_pkg::sync_state_t next_st;

	// Shift ones in; only the second stage is looked at
	always_comb begin
		next_st.stage = {st.stage[0], 1'b1};
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign reset_sync_n = st.stage[1];

endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the PHY event mask and special status block.
// Assumes the design sources are compiled first; one 100 MHz clock.
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [4:0]  addr;
		logic [15:0] wdata;
		logic [15:0] exp;
	} row_t;

	logic                     clock;
	logic                     resetn;
	phy_irq_pkg::reg_req_t    reg_req;
	phy_irq_pkg::phy_status_t phy_stat;
	logic [6:0]               event_pulse;
	logic [15:0]              rdata;
	logic                     irq;
	int                       mismatches;
	int                       checks;
	row_t                     rows [5];
	logic [2:0]               codes [4];
	logic [15:0]              seen;

	phy_irq_mask_special_status dut (
		.clock       (clock),
		.resetn      (resetn),
		.reg_req     (reg_req),
		.phy_stat    (phy_stat),
		.event_pulse (event_pulse),
		.rdata       (rdata),
		.irq         (irq)
	);

	// Free running clock
	initial clock = 1'b0;
	always #5 clock = ~clock;

	// Compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, got, exp);
		end
	endtask

	// One-cycle write strobe
	task automatic bus_write(input logic [4:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_req.addr <= a;
		reg_req.wdata <= d;
		reg_req.write <= 1'b1;
		@(posedge clock);
		reg_req.write <= 1'b0;
	endtask

	// One-cycle read strobe, data taken in the following cycle
	task automatic bus_read(input logic [4:0] a, output logic [15:0] d);
		@(posedge clock);
		reg_req.addr <= a;
		reg_req.read <= 1'b1;
		@(posedge clock);
		reg_req.read <= 1'b0;
		#1;
		d = rdata;
	endtask

	// One-cycle burst of event inputs
	task automatic pulse(input logic [6:0] v);
		@(posedge clock);
		event_pulse <= v;
		@(posedge clock);
		event_pulse <= 7'h00;
	endtask

	// Reset with a chosen MII mode, irq and rdata[15:1] quiet while held
	task automatic do_reset(input logic ext);
		@(posedge clock);
		resetn <= 1'b0;
		phy_stat.ext_mii_mode <= ext;
		phy_stat.speed_valid <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
		chk({rdata[15:1], irq}, 16'h0000);
		@(posedge clock);
		resetn <= 1'b1;
		repeat (3) @(posedge clock);
	endtask

	task automatic give_verdict;
		$display("mismatches=%0d checks=%0d", mismatches, checks);
		if (mismatches == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Watchdog against a hang
	initial begin
		#20us;
		mismatches++;
		give_verdict;
	end

	// Main sequence
	initial begin
		resetn = 1'b0;
		reg_req = '0;
		phy_stat = '0;
		event_pulse = 7'h00;
		mismatches = 0;
		checks = 0;
		rows[0] = '{5'h1e, 16'hffff, 16'h00fe};
		rows[1] = '{5'h1e, 16'h0000, 16'h0000};
		rows[2] = '{5'h1f, 16'h0043, 16'h004b};
		rows[3] = '{5'h05, 16'hffff, 16'h0000};
		rows[4] = '{5'h1c, 16'h0000, 16'h0000};
		codes = '{3'h1, 3'h2, 3'h5, 3'h6};
		do_reset(1'b1);
		// Reset values
		bus_read(5'h1e, seen);
		chk(seen, 16'h0000);
		bus_read(5'h1f, seen);
		chk(seen, 16'h0048);
		bus_read(5'h1d, seen);
		chk(seen, 16'h0000);
		// Table of write then read back
		foreach (rows[i]) begin
			bus_write(rows[i].addr, rows[i].wdata);
			bus_read(rows[i].addr, seen);
			chk(seen, rows[i].exp);
		end
		// Each mask bit alone, all events fired
		for (int i = 0; i < 7; i++) begin
			bus_write(5'h1e, 16'h0002 << i);
			pulse(7'h7f);
			@(posedge clock);
			#1;
			chk({15'h0000, irq}, 16'h0001);
			bus_read(5'h1d, seen);
			chk(seen, 16'h0002 << i);
			@(posedge clock);
			#1;
			chk({15'h0000, irq}, 16'h0000);
		end
		bus_read(5'h1d, seen);
		chk(seen, 16'h0000);
		// Clear register drops selected flags
		bus_write(5'h1e, 16'h00fe);
		pulse(7'h7f);
		bus_write(5'h1c, 16'h0006);
		bus_read(5'h1d, seen);
		chk(seen, 16'h00f8);
		pulse(7'h7f);
		bus_write(5'h1c, 16'h00fe);
		@(posedge clock);
		#1;
		chk({15'h0000, irq}, 16'h0000);
		// Event beside a flag read: the event wins, then shows once
		@(posedge clock);
		event_pulse <= 7'h01;
		reg_req.addr <= 5'h1d;
		reg_req.read <= 1'b1;
		@(posedge clock);
		event_pulse <= 7'h00;
		#1;
		chk(rdata, 16'h0000);
		@(posedge clock);
		reg_req.read <= 1'b0;
		#1;
		chk(rdata, 16'h0002);
		chk({15'h0000, irq}, 16'h0001);
		@(posedge clock);
		#1;
		chk(rdata, 16'h0000);
		chk({15'h0000, irq}, 16'h0000);
		// Speed codes with negotiation done
		@(posedge clock);
		phy_stat.autoneg_done <= 1'b1;
		phy_stat.speed_valid <= 1'b1;
		foreach (codes[k]) begin
			@(posedge clock);
			phy_stat.speed_code <= codes[k];
			repeat (2) @(posedge clock);
			bus_read(5'h1f, seen);
			chk(seen, {3'h0, 1'h1, 7'h02, codes[k], 2'h3});
		end
		@(posedge clock);
		phy_stat.autoneg_done <= 1'b0;
		repeat (2) @(posedge clock);
		bus_read(5'h1f, seen);
		chk(seen, {3'h0, 1'h0, 7'h02, 3'h6, 2'h3});
		// Mid-run reset without external MII
		do_reset(1'b0);
		bus_read(5'h1f, seen);
		chk(seen, 16'h0040);
		bus_read(5'h1e, seen);
		chk(seen, 16'h0000);
		give_verdict;
	end
endmodule
